// ### bench/coau_core_sva.sv
`default_nettype none
module coau_core_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] fetch_addr,
	input wire logic [7:0] mem_addr,
	input wire logic register_bank_select,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] accumulator,
	input wire logic [7:0] index_reg,
	input wire logic [7:0] flags
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	reset_state_a: assert property ($fell(reset) |-> fetch_addr == 16'h0000
		&& index_reg == 8'h00 && accumulator == 8'h00 && flags == 8'h02) else $error("reset state");
	pc_step_a: assert property (!$past(reset) && fetch_addr != $past(fetch_addr)
		|-> fetch_addr == $past(fetch_addr) + 16'h0001) else $error("pc step");
	pc_hold_a: assert property (mem_rd |=> $stable(fetch_addr)) else $error("pc moved");
	rd_gap_a: assert property (mem_rd |=> !mem_rd && !mem_wr) else $error("read strobe");
	wr_pulse_a: assert property ($rose(mem_wr) |=> $fell(mem_wr)) else $error("write strobe");
	wr_after_rd_a: assert property (mem_wr |-> $past(mem_rd, 2) || $past(mem_rd, 3))
		else $error("write without read");
	addr_hold_a: assert property (mem_wr |-> $stable(mem_addr)) else $error("address moved");
	regs_hold_a: assert property (mem_wr |-> $stable(accumulator) && $stable(index_reg))
		else $error("register changed on write");
	bank_sel_a: assert property ($stable(flags) [*2] |-> register_bank_select == flags[4])
		else $error("bank select");
	cover property (mem_rd);
	cover property (mem_wr);
	cover property (register_bank_select);
endmodule
bind coau_core coau_core_sva sva (.clk(clk), .reset(reset), .fetch_addr(fetch_addr),
	.mem_addr(mem_addr), .register_bank_select(register_bank_select), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .accumulator(accumulator), .index_reg(index_reg), .flags(flags));
`default_nettype wire

// ### bench/coau_mem_model.sv
`default_nettype none
module coau_mem_model (
	input wire logic clk,
	input wire logic [15:0] fetch_addr,
	output logic [7:0] fetch_data,
	input wire logic [7:0] mem_addr,
	input wire logic mem_reg_space,
	input wire logic register_bank_select,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] prog [0:255];
	logic [7:0] ram [0:255];
	logic [7:0] regs [0:511];
	logic [8:0] ra;
	logic [7:0] rd_val;
	logic [7:0] last_rd = 8'h00;
	assign fetch_data = prog[fetch_addr[7:0]];
	assign ra = {register_bank_select, mem_addr};
	assign rd_val = mem_reg_space ? regs[ra] : ram[mem_addr];
	// the core samples in the strobe cycle; an idle bus shows the inverse of the last word
	assign mem_rdata = mem_rd ? rd_val : ~last_rd;
	always @(posedge clk) begin
		if (mem_rd)
			last_rd <= rd_val;
		if (mem_wr && mem_reg_space)
			regs[ra] <= mem_wdata;
		else if (mem_wr)
			ram[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// ### bench/cpu_operand_addressing_unit_test.sv
`default_nettype none
module cpu_operand_addressing_unit_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] fetch_addr;
	logic [7:0] fetch_data, mem_addr, mem_wdata, mem_rdata, accumulator, index_reg, flags;
	logic [7:0] stack_pointer;
	logic mem_reg_space, register_bank_select, mem_rd, mem_wr;
	int fails = 0;
	int cmp_count = 0;
	always #12.5 clk = ~clk;
	coau_core dut (.clk(clk), .reset(reset), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
		.mem_addr(mem_addr), .mem_reg_space(mem_reg_space), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.register_bank_select(register_bank_select), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .accumulator(accumulator), .index_reg(index_reg),
		.flags(flags), .stack_pointer(stack_pointer));
	coau_mem_model mem (.clk(clk), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
		.mem_addr(mem_addr), .mem_reg_space(mem_reg_space), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.register_bank_select(register_bank_select), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	// unused program space holds the two-byte no-op
	task ld(input logic [7:0] q[$]);
		foreach (mem.prog[i])
			mem.prog[i] = i < q.size() ? q[i] : 8'h07;
	endtask
	task rst;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
	endtask
	// ncyc counts edges from reset release until the end address is seen
	task run(input logic [7:0] endpc, input logic [7:0] ncyc);
		int n;
		n = 0;
		while (n < 200 && fetch_addr !== {8'h00, endpc}) begin
			@(posedge clk);
			n++;
		end
		chk("pc reached", 8'h01, {7'h00, fetch_addr === {8'h00, endpc}});
		chk("cycles", ncyc, 8'(n));
		repeat (6) @(posedge clk);
	endtask
	task t_imm;
		ld({8'h00, 8'h10, 8'h40, 8'h07, 8'h10, 8'h33, 8'h18, 8'h05, 8'h08, 8'h12});
		rst;
		run(8'h0A, 8'h13);
		chk("acc", 8'h17, accumulator);
		chk("sp", 8'h33, stack_pointer);
		chk("idx", 8'h05, index_reg);
		chk("flags", 8'h12, flags);
		chk("bank", 8'h01, {7'h00, register_bank_select});
		$display("t_imm done");
	endtask
	task t_reset;
		rst;
		@(negedge clk);
		chk("pc lo", 8'h00, fetch_addr[7:0]);
		chk("pc hi", 8'h00, fetch_addr[15:8]);
		chk("idx", 8'h00, index_reg);
		chk("acc", 8'h00, accumulator);
		chk("bank", 8'h00, {7'h00, register_bank_select});
		chk("flags", 8'h02, flags);
		@(posedge clk);
		@(negedge clk);
		chk("pc first", 8'h01, fetch_addr[7:0]);
		@(posedge clk);
		$display("t_reset done");
	endtask
	task t_mem;
		ld({8'h08, 8'h10, 8'h18, 8'h10, 8'h01, 8'h20, 8'h42, 8'h12, 8'h3A, 8'hF8, 8'h5B, 8'h30,
			8'h04, 8'h40, 8'h45, 8'h50, 8'h07, 8'h26, 8'hE0, 8'h09});
		mem.ram[8'h20] = 8'h11;
		mem.ram[8'h22] = 8'h05;
		mem.ram[8'h30] = 8'h01;
		mem.ram[8'h50] = 8'h03;
		mem.regs[9'h108] = 8'h22;
		rst;
		run(8'h14, 8'h25);
		chk("acc", 8'h16, accumulator);
		chk("idx", 8'h22, index_reg);
		chk("ram30", 8'h23, mem.ram[8'h30]);
		chk("ram62", 8'h16, mem.ram[8'h62]);
		chk("ram50", 8'h0A, mem.ram[8'h50]);
		chk("reg102", 8'h09, mem.regs[9'h102]);
		$display("t_mem done");
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#50000;
		fails++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge clk);
		t_imm;
		t_reset;
		t_mem;
		final_report;
	end
endmodule
`default_nettype wire

// ### pkg/coau_consts.svh
`ifndef COAU_CONSTS_SVH
`define COAU_CONSTS_SVH
`define COAU_PC_RESET 16'h0000
`define COAU_REG_RESET 8'h00
`define COAU_FLAG_RESET 8'h02
`define COAU_FLAG_BANK_BIT 4
`define COAU_LEN_SHORT 16'h0002
`define COAU_LEN_LONG 16'h0003
`define COAU_MODE_LSB 0
`define COAU_DST_LSB 3
`define COAU_SPACE_BIT 5
`define COAU_ARITH_BIT 6
`endif

// ### pkg/coau_pkg.sv
`default_nettype none
package coau_pkg;
	typedef enum logic [2:0] {
		COAU_SRC_IMM = 3'h0,
		COAU_SRC_DIR = 3'h1,
		COAU_SRC_IDX = 3'h2,
		COAU_DST_DIR = 3'h3,
		COAU_DST_IDX = 3'h4,
		COAU_DST_DIR_IMM = 3'h5,
		COAU_DST_IDX_IMM = 3'h6,
		COAU_MODE_NONE = 3'h7
	} coau_mode_t;
	typedef enum logic [1:0] {
		COAU_REG_ACC = 2'h0,
		COAU_REG_FLAG = 2'h1,
		COAU_REG_SP = 2'h2,
		COAU_REG_IDX = 2'h3
	} coau_reg_t;
	typedef enum logic [3:0] {
		COAU_ST_FETCH = 4'h1,
		COAU_ST_OPER = 4'h2,
		COAU_ST_READ = 4'h4,
		COAU_ST_WRITE = 4'h8
	} coau_state_t;
endpackage
`default_nettype wire

// ### src/coau_alu.sv
`default_nettype none
module coau_alu (
	input wire logic clk,
	input wire logic reset,
	input wire logic arith,
	input wire logic [7:0] src,
	input wire logic [7:0] other,
	output logic [7:0] result
);
	typedef struct packed {
		logic [7:0] result;
	} coau_alu_state_t;
	coau_alu_state_t r, next_r;
	always_comb begin
		next_r = r;
		// arithmetic combines both sources; a move passes the source
		next_r.result = arith ? 8'(src + other) : src;
		if (reset) begin
			next_r.result = 8'h00;
		end
	end
	always_ff @(posedge clk) begin
		r <= next_r;
	end
	assign result = r.result;
endmodule
`default_nettype wire

// ### src/coau_core.sv
`include "coau_consts.svh"
`default_nettype none
// Functional notes
// - 16-bit program counter, clears at reset, no software access.
// - immediate source uses operand literal; writes A, F, SP or X per opcode.
// - immediate arithmetic combines destination register with the literal.
// - five single-operand modes are two bytes long.
// - destination-immediate modes are three bytes long.
// - direct source reads location at operand; result to A or X.
// - indexed source address is index register plus operand.
// - source-mode arithmetic uses selected A or X as second operand and result.
// - direct destination writes A or X to operand address; arithmetic reads it.
// - indexed destination writes accumulator to X plus operand; A unchanged.
// - direct-destination-immediate: operand1 address, operand2 source.
// - indexed-destination-immediate: X plus operand1 target, operand2 source.
// - 8-bit index register clears at reset, feeds every indexed mode.
// - flag bit 4 selects register-space bank.
module coau_core (
	input wire logic clk,
	input wire logic reset,
	output logic [15:0] fetch_addr,
	input wire logic [7:0] fetch_data,
	output logic [7:0] mem_addr,
	output logic mem_reg_space,
	output logic register_bank_select,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] accumulator,
	output logic [7:0] index_reg,
	output logic [7:0] flags,
	output logic [7:0] stack_pointer
);
	import coau_pkg::*;

	typedef struct packed {
		coau_state_t state;
		logic [15:0] program_counter;
		logic [7:0] acc;
		logic [7:0] idx;
		logic [7:0] flg;
		logic [7:0] sp;
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [1:0] nbytes;
		logic [7:0] maddr;
		logic space;
		logic rd;
		logic wr;
		logic [7:0] wdata;
		logic [7:0] other;
	} coau_core_state_t;

	coau_core_state_t r, next_r;
	logic [7:0] alu_result;

	// opcode layout: [2:0] mode, [4:3] register, [5] register space, [6] arithmetic
	function automatic coau_mode_t op_mode(input logic [7:0] op);
		op_mode = coau_mode_t'(op[`COAU_MODE_LSB +: 3]);
	endfunction

	function automatic logic [1:0] op_len(input logic [7:0] op);
		coau_mode_t m;
		m = op_mode(op);
		if (m == COAU_DST_DIR_IMM || m == COAU_DST_IDX_IMM) begin
			op_len = 2'h3;
		end else begin
			op_len = 2'h2;
		end
	endfunction

	function automatic logic [7:0] reg_value(input coau_core_state_t s, input coau_reg_t sel);
		case (sel)
			COAU_REG_ACC: reg_value = s.acc;
			COAU_REG_FLAG: reg_value = s.flg;
			COAU_REG_SP: reg_value = s.sp;
			default: reg_value = s.idx;
		endcase
	endfunction

	coau_mode_t mode;
	coau_reg_t sel;
	logic arith;
	logic [7:0] imm_other;
	assign mode = op_mode(r.opcode);
	assign sel = coau_reg_t'(r.opcode[`COAU_DST_LSB +: 2]);
	assign arith = r.opcode[`COAU_ARITH_BIT];
	assign imm_other = reg_value(r, sel);

	// alu registers its result, so every mode except COAU_MODE_NONE passes READ and WRITE takes it one cycle later
	coau_alu u_alu (
		.clk(clk),
		.reset(reset),
		.arith(arith),
		.src((r.state == COAU_ST_READ && mode inside {COAU_SRC_DIR, COAU_SRC_IDX})
			? mem_rdata : r.wdata),
		.other((r.state == COAU_ST_READ && mode inside {COAU_DST_DIR, COAU_DST_IDX,
			COAU_DST_DIR_IMM, COAU_DST_IDX_IMM}) ? mem_rdata : r.other),
		.result(alu_result)
	);

	always_comb begin
		next_r = r;
		next_r.rd = 1'b0;
		next_r.wr = 1'b0;
		case (r.state)
			COAU_ST_FETCH: begin
				next_r.opcode = fetch_data;
				next_r.nbytes = op_len(fetch_data);
				next_r.program_counter = r.program_counter + 16'h0001;
				next_r.state = COAU_ST_OPER;
			end
			COAU_ST_OPER: begin
				next_r.program_counter = r.program_counter + 16'h0001;
				next_r.space = r.opcode[`COAU_SPACE_BIT];
				case (mode)
					COAU_SRC_IMM: begin
						next_r.wdata = fetch_data;
						next_r.other = imm_other;
						next_r.state = COAU_ST_READ;
						next_r.rd = 1'b1;
					end
					COAU_SRC_DIR, COAU_DST_DIR: begin
						next_r.maddr = fetch_data;
						next_r.other = (sel == COAU_REG_IDX) ? r.idx : r.acc;
						next_r.wdata = next_r.other;
						next_r.rd = 1'b1;
						next_r.state = COAU_ST_READ;
					end
					COAU_SRC_IDX, COAU_DST_IDX: begin
						next_r.maddr = 8'(r.idx + fetch_data);
						next_r.other = (mode == COAU_DST_IDX) ? r.acc
							: ((sel == COAU_REG_IDX) ? r.idx : r.acc);
						next_r.wdata = next_r.other;
						next_r.rd = 1'b1;
						next_r.state = COAU_ST_READ;
					end
					COAU_DST_DIR_IMM, COAU_DST_IDX_IMM: begin
						if (r.nbytes == 2'h3) begin
							next_r.op1 = fetch_data;
							next_r.nbytes = 2'h1;
						end else begin
							next_r.maddr = (mode == COAU_DST_IDX_IMM)
								? 8'(r.idx + r.op1) : r.op1;
							next_r.wdata = fetch_data;
							next_r.other = fetch_data;
							next_r.rd = 1'b1;
							next_r.state = COAU_ST_READ;
						end
					end
					default: next_r.state = COAU_ST_FETCH;
				endcase
			end
			COAU_ST_READ: begin
				next_r.state = COAU_ST_WRITE;
			end
			COAU_ST_WRITE: begin
				next_r.state = COAU_ST_FETCH;
				case (mode)
					COAU_SRC_IMM: begin
						case (sel)
							COAU_REG_ACC: next_r.acc = alu_result;
							COAU_REG_FLAG: next_r.flg = alu_result;
							COAU_REG_SP: next_r.sp = alu_result;
							default: next_r.idx = alu_result;
						endcase
					end
					COAU_SRC_DIR, COAU_SRC_IDX: begin
						if (sel == COAU_REG_IDX) begin
							next_r.idx = alu_result;
						end else begin
							next_r.acc = alu_result;
						end
					end
					default: begin
						// memory destinations leave the accumulator untouched
						next_r.wdata = alu_result;
						next_r.wr = 1'b1;
					end
				endcase
			end
			default: next_r.state = COAU_ST_FETCH;
		endcase
		// immediate mode marks rd only to reuse the alu path; no bus read there
		if (r.state == COAU_ST_OPER && mode == COAU_SRC_IMM) begin
			next_r.rd = 1'b0;
		end
		if (reset) begin
			next_r.state = COAU_ST_FETCH;
			next_r.program_counter = `COAU_PC_RESET;
			next_r.acc = `COAU_REG_RESET;
			next_r.idx = `COAU_REG_RESET;
			next_r.flg = `COAU_FLAG_RESET;
			next_r.sp = `COAU_REG_RESET;
			next_r.opcode = 8'h00;
			next_r.op1 = 8'h00;
			next_r.nbytes = 2'h0;
			next_r.maddr = 8'h00;
			next_r.space = 1'b0;
			next_r.rd = 1'b0;
			next_r.wr = 1'b0;
			next_r.wdata = 8'h00;
			next_r.other = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end

	// program counter is visible only as the fetch address, never as data
	assign fetch_addr = r.program_counter;
	assign mem_addr = r.maddr;
	assign mem_reg_space = r.space;
	assign register_bank_select = r.flg[`COAU_FLAG_BANK_BIT];
	assign mem_rd = r.rd;
	assign mem_wr = r.wr;
	assign mem_wdata = r.wdata;
	assign accumulator = r.acc;
	assign index_reg = r.idx;
	assign flags = r.flg;
	assign stack_pointer = r.sp;
endmodule
`default_nettype wire
